// ### verilog/sar_readout_pkg.sv
// Constants shared by the serial conversion and readout logic.
// Assumes a single 20 MHz system clock samples the chip select and serial clock pins.
package sar_readout_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned MIN_SELECT_HIGH_TIME_NS = 50;
  localparam int unsigned MIN_SELECT_HIGH_CYCLES =
    (MIN_SELECT_HIGH_TIME_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned MIN_SCLK_PHASE_NS = 65;
  localparam int unsigned MIN_SCLK_PHASE_CYCLES =
    (MIN_SCLK_PHASE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

  // ----------------------------------------------------------------
  // Frame layout, counted in serial clock falling edges
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_BITS = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] ACQ_LAST_EDGE = 5'h06;
  localparam logic [CNT_W-1:0] FIRST_DATA_EDGE = 5'h08;
  localparam logic [CNT_W-1:0] LAST_DECIDE_EDGE = 5'h16;
  localparam logic [CNT_W-1:0] LAST_DATA_EDGE = 5'h17;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h18;
  localparam logic [CNT_W-1:0] CNT_SATURATE = 5'h19;
  localparam logic [RESULT_BITS-1:0] TRIAL_MSB = 16'h8000;
  localparam logic [RESULT_BITS-1:0] CODE_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SHUTDOWN = 4'b0001,
    ST_ACQUIRE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_DONE = 4'b1000
  } seq_state_t;

endpackage

// ### verilog/sar_adc_serial_readout.sv
// Serial conversion and readout sequencer of a 16-bit successive-approximation converter.
// Assumes cs_n, sclk and the comparator level are asynchronous and are synchronised here;
// the analog track-and-hold, capacitive DAC and comparator sit outside this module.
`timescale 1ns/1ps

module sar_adc_serial_readout (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic cmp_above,
  output logic dout,
  output logic dout_oe,
  output logic power_on,
  output logic track,
  output logic [15:0] dac_code,
  output logic [15:0] result_data,
  output logic result_valid,
  input wire logic result_ready
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Each serial clock phase lasts at least 65 ns, longer than one 50 ns system clock,
  // so every level is sampled at least once and no edge is missed.
  logic cs_m_q;
  logic cs_s_q;
  logic cs_d_q;
  logic sclk_m_q;
  logic sclk_s_q;
  logic sclk_d_q;
  logic cmp_m_q;
  logic cmp_s_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_d_q <= 1'b0;
      cmp_m_q <= 1'b0;
      cmp_s_q <= 1'b0;
    end
    else if (ce)
    begin
      cs_m_q <= cs_n;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
      sclk_m_q <= sclk;
      sclk_s_q <= sclk_m_q;
      sclk_d_q <= sclk_s_q;
      cmp_m_q <= cmp_above;
      cmp_s_q <= cmp_m_q;
    end
  end

  logic cs_fall;
  logic sclk_fall;
  assign cs_fall = cs_d_q & ~cs_s_q;
  // Falling edges only count while selected; the clock idles low between frames.
  assign sclk_fall = sclk_d_q & ~sclk_s_q & ~cs_s_q;

  // ----------------------------------------------------------------
  // Falling edge counter
  // ----------------------------------------------------------------
  logic [sar_readout_pkg::CNT_W-1:0] cnt_q;
  logic [sar_readout_pkg::CNT_W-1:0] cnt_d;
  // Saturates past the frame so trailing edges cannot wrap into a new frame.
  assign cnt_d = (cnt_q == sar_readout_pkg::CNT_SATURATE) ? cnt_q : cnt_q + 5'h01;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else if (ce)
    begin
      if (cs_s_q)
        cnt_q <= '0;
      else if (sclk_fall)
        cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sar_readout_pkg::seq_state_t state_q;
  logic [15:0] sar_q;
  logic [15:0] trial_q;
  logic [15:0] decided;
  logic decide;
  logic done_evt;

  assign decide = sclk_fall && (state_q == sar_readout_pkg::ST_CONVERT);
  assign decided = cmp_s_q ? (sar_q | trial_q) : sar_q;
  assign done_evt = decide && (cnt_d == sar_readout_pkg::LAST_DECIDE_EDGE);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= sar_readout_pkg::ST_SHUTDOWN;
    else if (ce)
    begin
      if (cs_s_q)
        state_q <= sar_readout_pkg::ST_SHUTDOWN;
      else
      begin
        case (state_q)
          sar_readout_pkg::ST_SHUTDOWN:
            if (cs_fall)
              state_q <= sar_readout_pkg::ST_ACQUIRE;
          sar_readout_pkg::ST_ACQUIRE:
            if (sclk_fall && cnt_d == sar_readout_pkg::ACQ_LAST_EDGE)
              state_q <= sar_readout_pkg::ST_CONVERT;
          sar_readout_pkg::ST_CONVERT:
            if (done_evt)
              state_q <= sar_readout_pkg::ST_DONE;
          sar_readout_pkg::ST_DONE:
            state_q <= sar_readout_pkg::ST_DONE;
          default:
            state_q <= sar_readout_pkg::ST_SHUTDOWN;
        endcase
      end
    end
  end

  // One trial bit per falling edge, MSB first: a bit is kept when the input lies at or
  // above the trial level, which gives a straight unipolar binary code.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sar_q <= sar_readout_pkg::CODE_ZERO;
      trial_q <= sar_readout_pkg::CODE_ZERO;
    end
    else if (ce)
    begin
      if (cs_s_q)
      begin
        sar_q <= sar_readout_pkg::CODE_ZERO;
        trial_q <= sar_readout_pkg::CODE_ZERO;
      end
      else if (state_q == sar_readout_pkg::ST_ACQUIRE && sclk_fall &&
               cnt_d == sar_readout_pkg::ACQ_LAST_EDGE)
      begin
        sar_q <= sar_readout_pkg::CODE_ZERO;
        trial_q <= sar_readout_pkg::TRIAL_MSB;
      end
      else if (decide)
      begin
        sar_q <= decided;
        trial_q <= trial_q >> 1;
      end
    end
  end

  assign dac_code = sar_q | trial_q;
  assign power_on = ~cs_s_q;
  assign track = (state_q == sar_readout_pkg::ST_ACQUIRE);

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Picks the result bit shown after falling edge n, or zero outside the data window.
  function automatic logic frame_bit(input logic [4:0] n, input logic [15:0] word);
    logic [4:0] idx;
    idx = sar_readout_pkg::LAST_DATA_EDGE - n;
    if (n < sar_readout_pkg::FIRST_DATA_EDGE || n > sar_readout_pkg::LAST_DATA_EDGE)
      frame_bit = 1'b0;
    else
      frame_bit = word[idx[3:0]];
  endfunction

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end
    else if (ce)
    begin
      dout_oe <= ~cs_s_q;
      if (cs_s_q || cs_fall)
        dout <= 1'b0;
      else if (sclk_fall)
        dout <= frame_bit(cnt_d, sar_q);
    end
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  // A finished word waits in a holding slot until the two-entry buffer has room, so a
  // stalled consumer loses nothing unless it stays stalled past a further conversion.
  logic pend_q;
  logic [15:0] pend_word_q;
  logic [15:0] buf_mem [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] fill_q;
  logic in_ready;
  logic push;
  logic pop;

  assign in_ready = (fill_q != 2'h2);
  assign push = pend_q && in_ready;
  assign result_valid = (fill_q != 2'h0);
  assign pop = result_valid && result_ready;
  assign result_data = buf_mem[rd_ptr_q];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_q <= 1'b0;
      pend_word_q <= sar_readout_pkg::CODE_ZERO;
    end
    else if (ce)
    begin
      pend_q <= done_evt | (pend_q & ~push);
      if (done_evt)
        pend_word_q <= decided;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      buf_mem[0] <= sar_readout_pkg::CODE_ZERO;
      buf_mem[1] <= sar_readout_pkg::CODE_ZERO;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fill_q <= 2'h0;
    end
    else if (ce)
    begin
      if (push)
      begin
        buf_mem[wr_ptr_q] <= pend_word_q;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push && !pop)
        fill_q <= fill_q + 2'h1;
      else if (pop && !push)
        fill_q <= fill_q - 2'h1;
    end
  end

endmodule

// ### tb/spi_host_model.sv
// Host model: a mode-zero SPI master that drives select and serial clock and reads dout.
// Assumes the bench calls its tasks at a falling edge of the 20 MHz system clock.
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  input wire logic dout,
  output logic cs_n,
  output logic sclk
);
  // Four system clocks a phase give 200 ns, above the 65 ns floor and under 4.8 MHz.
  localparam int PHASE = 4;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  task automatic pulse();
    sclk <= 1'b1;
    repeat (PHASE) @(negedge clk);
    sclk <= 1'b0;
    repeat (PHASE) @(negedge clk);
  endtask
  task automatic frame(input int edges, output logic [31:0] rx);
    rx = 32'h0000_0000;
    cs_n <= 1'b0;
    repeat (PHASE) @(negedge clk);
    for (int i = 0; i < edges; i++)
    begin
      rx = {rx[30:0], dout};
      pulse();
    end
    cs_n <= 1'b1;
    repeat (6) @(negedge clk);
  endtask
endmodule

// ### tb/sar_readout_chk.sv
// Checker on the pins of the serial readout sequencer.
// Assumes ce stays high while the select toggles; ce low pauses checking.
`timescale 1ns/1ps
module sar_readout_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic cmp_above,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic power_on,
  input wire logic track,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] result_data,
  input wire logic result_valid,
  input wire logic result_ready
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n || !ce);
  a_idle_released: assert property (cs_n [*5] |-> !dout_oe && !power_on && !track)
    else $error("output or power active while deselected");
  a_select_powered: assert property ((!cs_n) [*5] |-> dout_oe && power_on)
    else $error("not powered while selected");
  a_fall_drives_low: assert property ($rose(dout_oe) |-> !dout && track)
    else $error("select fall did not drive low and track");
  a_acq_ends: assert property ($fell(track) && dout_oe |-> dac_code == 16'h8000)
    else $error("conversion did not start with the top trial bit");
  a_dout_on_fall: assert property ($changed(dout) |-> !sclk || !dout_oe)
    else $error("dout changed while serial clock high");
  a_idle_code: assert property (!dout_oe |-> dac_code == 16'h0000)
    else $error("trial code not cleared in shutdown");
  a_acq_zeros: assert property (track |-> !dout)
    else $error("nonzero bit during acquisition");
  a_result_framed: assert property ($rose(result_valid) |-> dout_oe)
    else $error("result appeared outside a frame");
  cover property ($rose(result_valid));
  cover property ($fell(dout_oe));
  cover property (result_valid && result_ready);
endmodule
bind sar_adc_serial_readout sar_readout_chk i_chk (.clk(clk), .reset_n(reset_n), .ce(ce),
  .cs_n(cs_n), .sclk(sclk), .cmp_above(cmp_above), .dout(dout), .dout_oe(dout_oe),
  .power_on(power_on), .track(track), .dac_code(dac_code), .result_data(result_data),
  .result_valid(result_valid), .result_ready(result_ready));

// ### tb/tb_sar_adc_serial_readout.sv
// Self-checking bench: host model reads frames, an ideal comparator stands for the input.
// Assumes a 20 MHz clock and that all stimulus changes at falling clock edges.
`timescale 1ns/1ps
module tb_sar_adc_serial_readout;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic result_ready = 1'b0;
  logic cs_n, sclk, dout, dout_oe, power_on, track, result_valid;
  logic [15:0] dac_code, result_data;
  logic [15:0] vin = 16'h0000;
  logic [15:0] corner [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};
  logic [15:0] exp_q [$];
  logic [31:0] rx;
  int seed = 73816;
  int num_errors = 0;
  int check_count = 0;
  // The pin floats when released; the host only samples it while selected.
  wire dout_line = dout_oe ? dout : 1'bz;
  wire cmp_above = (vin >= dac_code);
  always #25 clk = ~clk;
  sar_adc_serial_readout i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .cs_n(cs_n),
    .sclk(sclk), .cmp_above(cmp_above), .dout(dout), .dout_oe(dout_oe), .power_on(power_on),
    .track(track), .dac_code(dac_code), .result_data(result_data),
    .result_valid(result_valid), .result_ready(result_ready));
  spi_host_model i_host (.clk(clk), .dout(dout_line), .cs_n(cs_n), .sclk(sclk));
  function automatic logic [31:0] frame_bits(input logic [15:0] code, input int edges);
    frame_bits = {16'h0000, code} << (edges - 24);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input int edges);
    i_host.frame(edges, rx);
    if (edges >= 24)
    begin
      check("serial frame", frame_bits(vin, edges), rx);
      exp_q.push_back(vin);
    end
  endtask
  task automatic drain();
    while (exp_q.size() > 0)
    begin
      for (int t = 0; t < 100 && result_valid !== 1'b1; t++) @(negedge clk);
      check("result valid", 32'h0000_0001, {31'h0, result_valid});
      check("result word", {16'h0000, exp_q.pop_front()}, {16'h0000, result_data});
      result_ready = 1'b1;
      @(negedge clk);
      result_ready = 1'b0;
      // A clock edge passes with ready low, so the next pop is a fresh request.
      @(negedge clk);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    // Corner codes first, then random ones; every third frame runs past the LSB.
    for (int i = 0; i < 12; i++)
    begin
      vin = (i < 4) ? corner[i] : 16'($random(seed));
      run((i % 3 == 2) ? 28 : 24);
      drain();
    end
    repeat (3) i_host.pulse();
    vin = 16'h5a5a;
    run(24);
    drain();
    vin = 16'ha5a5;
    // Abort one edge short of the last decision: bits seen so far must still be right.
    run(21);
    check("partial frame", frame_bits(vin, 24) >> 3, rx);
    check("valid after abort", 32'h0000_0000, {31'h0, result_valid});
    check("select released", 32'h0000_0000, {30'h0, dout_oe, power_on});
    // Three frames with the consumer stalled: two buffered, one held back.
    for (int i = 0; i < 3; i++)
    begin
      vin = 16'($random(seed));
      run(24);
    end
    // A low clock enable must freeze the buffer: a ready consumer pops nothing.
    ce = 1'b0;
    result_ready = 1'b1;
    repeat (4) @(negedge clk);
    ce = 1'b1;
    drain();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule
